// ==== hdl/mes_pkg.sv ====
// package of the modulator enable sequencer: offsets, fields, types
// assumes a 50 MHz oscillator clock and a 32-bit AHB-Lite register bus
`default_nettype none
package mes_pkg;
    // register byte offsets
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_FREQ = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
    localparam logic [31:0] OFS_MASK = 32'h0000_00fc;
    // control fields
    localparam int CTRL_DIGITAL_BIT = 0;
    localparam int CTRL_RUN_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0011;
    // frequency word: nco increment of the 4x clock
    localparam int NCO_WIDTH = 16;
    localparam logic [15:0] FREQ_RESET = 16'h0241;
    localparam logic [15:0] FREQ_MIN = 16'h0010;
    localparam logic [15:0] DITHER_DIVISOR = 16'h000a;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int DELAY_US = 500;
    localparam int DELAY_CYCLES = DELAY_US * CLK_MHZ;
    localparam int DITHER_STEP_CYCLES = 16384;
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [2:0]
    {
        ST_WAIT_SVR,
        ST_TRISTATE,
        ST_DELAY,
        ST_RUN
    } mes_state_type;

    // asynchronous pin and comparator levels
    typedef struct packed
    {
        logic mode_pin_zero;
        logic mode_pin_one;
        logic dither_pin_at_ground;
        logic dither_pin_at_supply;
        logic clock_io_pin;
        logic pll_locked;
        logic digital_supply_ok;
        logic busless_mode;
        logic busless_diagnostic_mode;
        logic diag_active;
        logic diag_done;
        logic diag_fault;
        logic die_temp_second;
        logic ext_temp_second;
        logic rail_headroom_ok;
        logic overvoltage_ok;
        logic total_supply_ok;
        logic reference_ok;
        logic low_supply_ok;
        logic main_supply_mute_ok;
        logic low_supply_mute_threshold_ok;
        logic svr_above_discharge;
        logic single_supply;
    } mes_pins_type;
endpackage
`default_nettype wire

// ==== hdl/mes_top.sv ====
// modulator enable sequencer with oscillator source selection
// assumes comparator levels arrive asynchronous; one AHB-Lite master
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mes_top
#(
    parameter int DELAY_CYCLES = mes_pkg::DELAY_CYCLES,
    parameter int DITHER_STEP_CYCLES = mes_pkg::DITHER_STEP_CYCLES
)
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // pins and comparators
    input wire mes_pkg::mes_pins_type PINS_IN,
    // clock pin driver
    output logic CLOCK_IO_PIN_OUT,
    output logic CLOCK_IO_PIN_OE_OUT,
    // modulator and svr charge control
    output logic MOD_CLK_OUT,
    output logic MOD_ENABLE_OUT,
    output logic MOD_MUTE_OUT,
    output logic SVR_CHARGE_OUT
);
    mes_pkg::mes_pins_type pins_meta;
    mes_pkg::mes_pins_type pins;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [15:0] freq;
    logic [15:0] next_freq;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rd_word;
    logic hready_q;
    logic [31:0] hrdata_q;
    logic thermal_ok;
    logic diag_passed;
    logic run_req;
    logic all_ok;
    logic mode_ok;
    logic pll_ok;
    logic supply_ok;
    mes_pkg::mes_state_type state;
    logic [31:0] delay_cnt;
    logic mod_en_q;
    logic mute_q;
    logic svr_charge_q;
    logic ext_sel;
    logic dither_on;
    logic [15:0] dither_max;
    logic signed [16:0] dither_ofs;
    logic dither_up;
    logic [31:0] dither_cnt;
    logic [15:0] nco_inc;
    logic [15:0] nco_acc;
    logic nco_msb_q;
    logic ext_q;
    logic tick4x;
    logic [1:0] div4;
    logic mod_clk_q;
    logic clk_pin_q;
    logic clk_oe_q;

    // two-stage synchroniser for all pins
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            pins_meta <= '0;
            pins <= '0;
        end
        else
        begin
            pins_meta <= PINS_IN;
            pins <= pins_meta;
        end
    end

    // ahb address phase capture
    wire addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end
        else
        begin
            wr_pend <= addr_ok && HWRITE_IN
                && (HSIZE_IN == mes_pkg::HSIZE_WORD);
            wr_addr <= HADDR_IN;
        end
    end

    // register write path, next values also feed reads
    always_comb
    begin
        next_ctrl = ctrl;
        next_freq = freq;
        if (wr_pend && wr_addr == mes_pkg::OFS_CTRL)
        begin
            next_ctrl = HWDATA_IN & mes_pkg::CTRL_MASK;
        end
        else if (wr_pend && wr_addr == mes_pkg::OFS_FREQ)
        begin
            if (HWDATA_IN[15:0] < mes_pkg::FREQ_MIN)
            begin
                next_freq = mes_pkg::FREQ_MIN;
            end
            else
            begin
                next_freq = HWDATA_IN[15:0];
            end
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl <= mes_pkg::CTRL_RESET;
            freq <= mes_pkg::FREQ_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
            freq <= next_freq;
        end
    end

    // read mux
    always_comb
    begin
        rd_word = '0;
        if ((HADDR_IN & mes_pkg::OFS_MASK) != HADDR_IN)
        begin
            rd_word = '0;
        end
        else if (HADDR_IN == mes_pkg::OFS_CTRL)
        begin
            rd_word = next_ctrl;
        end
        else if (HADDR_IN == mes_pkg::OFS_FREQ)
        begin
            rd_word = {16'h0000, next_freq};
        end
        else if (HADDR_IN == mes_pkg::OFS_STATUS)
        begin
            rd_word = {16'h0000, 3'h0, ext_sel, dither_on, diag_passed,
                       thermal_ok, run_req, mode_ok, pll_ok, supply_ok,
                       all_ok, mod_en_q, 3'(state)};
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            hrdata_q <= '0;
            hready_q <= 1'b1;
        end
        else
        begin
            hready_q <= 1'b1;
            if (addr_ok && !HWRITE_IN)
            begin
                hrdata_q <= rd_word;
            end
        end
    end

    // thermal flag: latched low by a second threshold
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            thermal_ok <= 1'b1;
        end
        else if (pins.die_temp_second || pins.ext_temp_second)
        begin
            thermal_ok <= 1'b0;
        end
    end

    // power-up diagnostic result and run request
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            diag_passed <= 1'b0;
        end
        else if (pins.diag_done && !pins.diag_fault)
        begin
            diag_passed <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            run_req <= 1'b0;
        end
        else if (!pins.digital_supply_ok)
        begin
            run_req <= 1'b0;
        end
        else if (pins.busless_mode)
        begin
            run_req <= 1'b1;
        end
        else if (pins.busless_diagnostic_mode)
        begin
            run_req <= diag_passed;
        end
        else
        begin
            run_req <= ctrl[mes_pkg::CTRL_RUN_BIT];
        end
    end

    // start-up conditions
    assign mode_ok = pins.mode_pin_zero || pins.mode_pin_one;
    assign pll_ok = pins.pll_locked
        || !ctrl[mes_pkg::CTRL_DIGITAL_BIT];
    assign supply_ok = pins.rail_headroom_ok && pins.overvoltage_ok
        && pins.total_supply_ok && pins.reference_ok
        && pins.low_supply_ok;
    assign all_ok = mode_ok && run_req && pll_ok && thermal_ok
        && supply_ok && !pins.diag_active;

    // enable sequencer
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            state <= mes_pkg::ST_WAIT_SVR;
            delay_cnt <= '0;
        end
        else
        begin
            case (state)
                mes_pkg::ST_WAIT_SVR:
                begin
                    if (!pins.single_supply || !pins.svr_above_discharge)
                    begin
                        state <= mes_pkg::ST_TRISTATE;
                    end
                end
                mes_pkg::ST_TRISTATE:
                begin
                    delay_cnt <= '0;
                    if (all_ok)
                    begin
                        state <= mes_pkg::ST_DELAY;
                    end
                end
                mes_pkg::ST_DELAY:
                begin
                    if (!all_ok)
                    begin
                        state <= mes_pkg::ST_TRISTATE;
                    end
                    else if (delay_cnt == 32'(DELAY_CYCLES - 1))
                    begin
                        state <= mes_pkg::ST_RUN;
                    end
                    else
                    begin
                        delay_cnt <= delay_cnt + 32'h0000_0001;
                    end
                end
                mes_pkg::ST_RUN:
                begin
                    if (!all_ok && pins.single_supply)
                    begin
                        state <= mes_pkg::ST_WAIT_SVR;
                    end
                    else if (!all_ok)
                    begin
                        state <= mes_pkg::ST_TRISTATE;
                    end
                end
                default:
                begin
                    state <= mes_pkg::ST_WAIT_SVR;
                end
            endcase
        end
    end

    // control outputs
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            mod_en_q <= 1'b0;
            mute_q <= 1'b1;
            svr_charge_q <= 1'b0;
        end
        else
        begin
            mod_en_q <= (state == mes_pkg::ST_RUN) && all_ok;
            mute_q <= !pins.main_supply_mute_ok
                || !pins.low_supply_mute_threshold_ok;
            svr_charge_q <= (state != mes_pkg::ST_WAIT_SVR);
        end
    end

    // oscillator source and dither
    assign ext_sel = pins.dither_pin_at_supply;
    assign dither_on = !pins.dither_pin_at_ground && !ext_sel;
    assign dither_max = freq / mes_pkg::DITHER_DIVISOR;

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            dither_ofs <= '0;
            dither_up <= 1'b1;
            dither_cnt <= '0;
        end
        else if (!dither_on)
        begin
            dither_ofs <= '0;
            dither_up <= 1'b1;
            dither_cnt <= '0;
        end
        else if (dither_cnt == 32'(DITHER_STEP_CYCLES - 1))
        begin
            dither_cnt <= '0;
            if (dither_up && dither_ofs >= $signed({1'b0, dither_max}))
            begin
                dither_up <= 1'b0;
                dither_ofs <= dither_ofs - 17'sd1;
            end
            else if (!dither_up && dither_ofs <= -$signed({1'b0, dither_max}))
            begin
                dither_up <= 1'b1;
                dither_ofs <= dither_ofs + 17'sd1;
            end
            else if (dither_up)
            begin
                dither_ofs <= dither_ofs + 17'sd1;
            end
            else
            begin
                dither_ofs <= dither_ofs - 17'sd1;
            end
        end
        else
        begin
            dither_cnt <= dither_cnt + 32'h0000_0001;
        end
    end

    assign nco_inc = 16'($signed({1'b0, freq}) + dither_ofs);

    // internal 4x oscillator and external 4x edge detect
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            nco_acc <= '0;
            nco_msb_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            nco_acc <= nco_acc + nco_inc;
            nco_msb_q <= nco_acc[mes_pkg::NCO_WIDTH - 1];
            ext_q <= pins.clock_io_pin;
        end
    end

    assign tick4x = ext_sel ? (pins.clock_io_pin && !ext_q)
        : (nco_acc[mes_pkg::NCO_WIDTH - 1] && !nco_msb_q);

    // divide by four to the common modulator clock
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            div4 <= '0;
            mod_clk_q <= 1'b0;
        end
        else
        begin
            if (tick4x)
            begin
                div4 <= div4 + 2'h1;
            end
            mod_clk_q <= div4[1];
        end
    end

    // clock pin: output unless external clock selected
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            clk_pin_q <= 1'b0;
            clk_oe_q <= 1'b0;
        end
        else
        begin
            clk_pin_q <= nco_msb_q;
            clk_oe_q <= !ext_sel;
        end
    end

    assign HRDATA_OUT = hrdata_q;
    assign HREADYOUT_OUT = hready_q;
    assign HRESP_OUT = 1'b0;
    assign CLOCK_IO_PIN_OUT = clk_pin_q;
    assign CLOCK_IO_PIN_OE_OUT = clk_oe_q;
    assign MOD_CLK_OUT = mod_clk_q;
    assign MOD_ENABLE_OUT = mod_en_q;
    assign MOD_MUTE_OUT = mute_q;
    assign SVR_CHARGE_OUT = svr_charge_q;

    // helper: consecutive cycles with all conditions met
    logic [31:0] ok_run;
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || !all_ok)
        begin
            ok_run <= '0;
        end
        else if (ok_run != 32'hffff_ffff)
        begin
            ok_run <= ok_run + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_cond_lost;
        mod_en_q && !all_ok;
    endsequence

    sequence s_enable_rise;
        $rose(mod_en_q);
    endsequence

    a_enable_drops: assert property (s_cond_lost |=> !mod_en_q)
        else $error("enable stayed on after condition lost");
    a_enable_delay: assert property (s_enable_rise
        |-> ok_run > 32'(DELAY_CYCLES))
        else $error("enable released before start-up delay");
    a_thermal_latch: assert property (!thermal_ok |=> !thermal_ok)
        else $error("thermal flag recovered without reset");
    a_svr_inhibit: assert property (state == mes_pkg::ST_WAIT_SVR
        |=> !svr_charge_q && !mod_en_q)
        else $error("svr charged while waiting for discharge");
    a_single_restart: assert property (state == mes_pkg::ST_RUN
        && !all_ok && pins.single_supply |=> state == mes_pkg::ST_WAIT_SVR)
        else $error("single supply restart skipped svr discharge");
    a_clock_pin_dir: assert property (RSTN_IN
        |=> clk_oe_q == !$past(ext_sel))
        else $error("clock pin direction wrong");
    a_no_ext_dither: assert property (ext_sel |=> dither_ofs == 0)
        else $error("dither applied to external clock");
    a_dither_band: assert property (
        dither_ofs <= $signed({1'b0, dither_max}) + 17'sd1
        && dither_ofs >= -$signed({1'b0, dither_max}) - 17'sd1)
        else $error("dither outside band");
    a_bus_run_bit: assert property (!pins.busless_mode
        && !pins.busless_diagnostic_mode && !ctrl[mes_pkg::CTRL_RUN_BIT]
        |=> !run_req)
        else $error("run request without run bit");
    a_pll_gate: assert property (ctrl[mes_pkg::CTRL_DIGITAL_BIT]
        && !pins.pll_locked |-> !all_ok)
        else $error("unlocked pll accepted with digital input");
endmodule // mes_top
`default_nettype wire

// ==== verification/mes_far_side.sv ====
// far-side model: mode pins, supply comparators, external clock source
// assumes the bench picks comparator levels; the clock pin is resolved here
`timescale 1ns/100ps
`default_nettype none
module mes_far_side
(
    // clock
    input wire logic clk_in,
    // levels chosen by the bench
    input wire mes_pkg::mes_pins_type levels_in,
    // clock pin as driven by the device
    input wire logic pin_drive_in,
    input wire logic pin_oe_in,
    // levels seen by the device
    output var mes_pkg::mes_pins_type pins_out
);
    logic ext_clk = 1'b0;
    logic [1:0] div = 2'h0;

    // external 4x source, period 8 cycles, still when not selected
    always @(posedge clk_in)
    begin
        if (levels_in.dither_pin_at_supply)
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
                ext_clk <= ~ext_clk;
        end
        else
        begin
            div <= 2'h0;
            ext_clk <= 1'b0;
        end
    end

    // wire level of the clock pin from both parties
    always_comb
    begin
        pins_out = levels_in;
        pins_out.clock_io_pin = pin_oe_in ? pin_drive_in : ext_clk;
    end
endmodule // mes_far_side
`default_nettype wire

// ==== verification/modulator_enable_sequencer_bench.sv ====
// self-checking bench of the modulator enable sequencer
// assumes mes_top with short delay and dither step parameters
`timescale 1ns/100ps
`default_nettype none
module modulator_enable_sequencer_bench;
    localparam int D = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, clk_pin, clk_oe;
    logic mod_clk, mod_en, mod_mute, svr_chg;
    // all conditions good, bus mode, split supply
    mes_pkg::mes_pins_type lv = 23'h51_01fc;
    mes_pkg::mes_pins_type pins, t;
    int errors = 0;
    int num_checks = 0;
    int n, a, b, lo, hi;
    logic [31:0] rd;
    int bad_bits[7] = '{4, 5, 6, 7, 8, 16, 13};

    always #10 clk = ~clk;

    mes_top #(.DELAY_CYCLES(D), .DITHER_STEP_CYCLES(4)) mes_top_inst (
        .CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .PINS_IN(pins),
        .CLOCK_IO_PIN_OUT(clk_pin), .CLOCK_IO_PIN_OE_OUT(clk_oe),
        .MOD_CLK_OUT(mod_clk), .MOD_ENABLE_OUT(mod_en),
        .MOD_MUTE_OUT(mod_mute), .SVR_CHARGE_OUT(svr_chg));

    mes_far_side mes_far_side_inst (.clk_in(clk), .levels_in(lv),
        .pin_drive_in(clk_pin), .pin_oe_in(clk_oe), .pins_out(pins));

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        chk(k < 50, "bus wait ran out");
        if (k >= 50)
            test_done();
    endtask

    // one single transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] ad,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= mes_pkg::HTRANS_NONSEQ;
        haddr <= ad;
        hwrite <= wr;
        hsize <= mes_pkg::HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rchk(input logic [31:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0);
        chk(rd === exp, "register read");
    endtask

    task automatic rise();
        n = 0;
        while (mod_en !== 1'b1 && n < 5 * D)
        begin
            @(posedge clk);
            n++;
        end
        chk(n >= D && n <= D + 10, "enable delay");
        if (n >= 5 * D)
            test_done();
    endtask

    task automatic fall();
        n = 0;
        while (mod_en !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(n <= 6, "enable drop");
        if (n >= 20)
            test_done();
    endtask

    task automatic stay(input logic v, input int k);
        logic ok;
        ok = 1'b1;
        repeat (k)
        begin
            @(posedge clk);
            if (mod_en !== v)
                ok = 1'b0;
        end
        chk(ok, "enable level");
    endtask

    task automatic count(input int k);
        logic pc, pm;
        a = 0;
        b = 0;
        pc = clk_pin;
        pm = mod_clk;
        repeat (k)
        begin
            @(posedge clk);
            if (clk_pin === 1'b1 && pc === 1'b0)
                a++;
            if (mod_clk === 1'b1 && pm === 1'b0)
                b++;
            pc = clk_pin;
            pm = mod_clk;
        end
    endtask

    task automatic sweep(input int k);
        lo = 1000;
        hi = 0;
        repeat (k)
        begin
            count(640);
            lo = (a < lo) ? a : lo;
            hi = (a > hi) ? a : hi;
        end
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        chk(mod_en === 1'b0 && mod_mute === 1'b1 && clk_oe === 1'b0 &&
            hreadyout === 1'b1 && hresp === 1'b0, "reset outputs");
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    initial
    begin
        do_reset();
        rchk(mes_pkg::OFS_CTRL, mes_pkg::CTRL_RESET);
        rchk(mes_pkg::OFS_FREQ, {16'h0, mes_pkg::FREQ_RESET});
        rchk(32'h0000_0010, 32'h0);
        stay(1'b0, 3 * D);
        bus(1'b1, mes_pkg::OFS_CTRL, 32'h0000_0010);
        rise();
        rchk(mes_pkg::OFS_CTRL, 32'h0000_0010);
        rchk(mes_pkg::OFS_STATUS, 32'h0000_03fb);
        foreach (bad_bits[j])
        begin
            lv[bad_bits[j]] <= ~lv[bad_bits[j]];
            fall();
            lv[bad_bits[j]] <= ~lv[bad_bits[j]];
            rise();
        end
        lv.mode_pin_one <= 1'b1;
        @(posedge clk);
        lv.mode_pin_zero <= 1'b0;
        stay(1'b1, 10);
        lv.mode_pin_one <= 1'b0;
        fall();
        lv.mode_pin_zero <= 1'b1;
        rise();
        chk(mod_mute === 1'b0, "mute while good");
        lv.main_supply_mute_ok <= 1'b0;
        repeat (5) @(posedge clk);
        chk(mod_mute === 1'b1, "main supply mute");
        lv.main_supply_mute_ok <= 1'b1;
        repeat (5) @(posedge clk);
        lv.low_supply_mute_threshold_ok <= 1'b0;
        repeat (5) @(posedge clk);
        chk(mod_mute === 1'b1, "low supply mute");
        lv.low_supply_mute_threshold_ok <= 1'b1;
        repeat (3 * D) @(posedge clk);
        chk(mod_en === 1'b1 && mod_mute === 1'b0, "mute release");
        bus(1'b1, mes_pkg::OFS_CTRL, 32'h0000_0011);
        fall();
        lv.pll_locked <= 1'b1;
        rise();
        bus(1'b1, mes_pkg::OFS_CTRL, 32'h0000_0010);
        lv.pll_locked <= 1'b0;
        stay(1'b1, 3 * D);
        bus(1'b1, mes_pkg::OFS_FREQ, 32'h0);
        rchk(mes_pkg::OFS_FREQ, {16'h0, mes_pkg::FREQ_MIN});
        bus(1'b1, mes_pkg::OFS_FREQ, 32'h0000_2000);
        count(640);
        chk(a >= 79 && a <= 81 && clk_oe === 1'b1, "4x out");
        chk(b * 4 >= a - 4 && b * 4 <= a + 4, "common clock");
        sweep(4);
        chk(lo >= 79 && hi <= 81, "steady frequency");
        lv.dither_pin_at_ground <= 1'b0;
        sweep(21);
        chk(lo >= 70 && hi <= 92 && hi - lo >= 8, "dither span");
        rchk(mes_pkg::OFS_STATUS, 32'h0000_0bfb);
        lv.dither_pin_at_supply <= 1'b1;
        repeat (40) @(posedge clk);
        count(640);
        chk(b >= 19 && b <= 21 && clk_oe === 1'b0, "external clock");
        count(640);
        chk(b >= 19 && b <= 21, "no dither on external");
        rchk(mes_pkg::OFS_STATUS, 32'h0000_13fb);
        t = lv;
        t.dither_pin_at_supply = 1'b0;
        t.dither_pin_at_ground = 1'b1;
        t.single_supply = 1'b1;
        t.svr_above_discharge = 1'b1;
        lv <= t;
        repeat (3 * D) @(posedge clk);
        lv.rail_headroom_ok <= 1'b0;
        fall();
        lv.rail_headroom_ok <= 1'b1;
        stay(1'b0, 3 * D);
        chk(svr_chg === 1'b0, "svr charge held");
        lv.svr_above_discharge <= 1'b0;
        rise();
        chk(svr_chg === 1'b1, "svr charging");
        lv.single_supply <= 1'b0;
        bus(1'b1, mes_pkg::OFS_CTRL, 32'h0);
        fall();
        lv.busless_mode <= 1'b1;
        rise();
        lv.digital_supply_ok <= 1'b0;
        fall();
        t = lv;
        t.busless_mode = 1'b0;
        t.busless_diagnostic_mode = 1'b1;
        t.digital_supply_ok = 1'b1;
        t.diag_fault = 1'b1;
        lv <= t;
        repeat (4) @(posedge clk);
        lv.diag_done <= 1'b1;
        stay(1'b0, 3 * D);
        lv.diag_fault <= 1'b0;
        rise();
        lv.die_temp_second <= 1'b1;
        fall();
        lv.die_temp_second <= 1'b0;
        stay(1'b0, 3 * D);
        do_reset();
        rise();
        lv.ext_temp_second <= 1'b1;
        fall();
        test_done();
    end
endmodule // modulator_enable_sequencer_bench
`default_nettype wire
